// >>> hdl/lrd_consts.svh
// Constants for the link request controller
`ifndef LRD_CONSTS_SVH
`define LRD_CONSTS_SVH

// Register word addresses
`define LRD_REG_CMD 4'h0
`define LRD_REG_STATUS 4'h1
`define LRD_REG_RESULT 4'h2
`define LRD_REG_MIRROR 4'h3

// Command word field positions
`define LRD_CMD_TYPE_LSB 0
`define LRD_CMD_PRIO_LSB 3
`define LRD_CMD_ADDR_LSB 7
`define LRD_CMD_DATA_LSB 11

// Status word bit positions
`define LRD_ST_PENDING 0
`define LRD_ST_WON 1
`define LRD_ST_LOST 2
`define LRD_ST_REFUSED 3
`define LRD_ST_RDDONE 4
`define LRD_ST_RDPEND 5
`define LRD_ST_QUEUED 6
`define LRD_ST_SENDING 7
`define LRD_ST_FLAGS_LSB 8

// Request type codes
`define LRD_REQ_IMM 3'h0
`define LRD_REQ_ISO 3'h1
`define LRD_REQ_PRI 3'h2
`define LRD_REQ_FAIR 3'h3
`define LRD_REQ_READ 3'h4
`define LRD_REQ_WRITE 3'h5

// Control line codes
`define LRD_CTL_IDLE 2'h0
`define LRD_CTL_STATUS 2'h1
`define LRD_CTL_RECEIVE 2'h2
`define LRD_CTL_TRANSMIT 2'h3

// Frame lengths in bits
`define LRD_LEN_BUS 5'h0B
`define LRD_LEN_READ 5'h09
`define LRD_LEN_WRITE 5'h11

// Status transfer lengths in clocks
`define LRD_STAT_SHORT 4'h2
`define LRD_STAT_FULL 4'h8

// Idle cycles the link drives when giving the bus back
`define LRD_RELEASE_CYC 2'h2

// Timing
`define LRD_ACK_GUARD_NS 160
`define LRD_CLK_MHZ 50

`endif

// >>> hdl/lrd_pkg.sv
// Types for the link request controller
package lrd_pkg;

    typedef enum logic [1:0] {
        LRD_IDLE = 2'b01,
        LRD_SEND = 2'b10
    } lrd_fsm_t;

    typedef struct packed {
        lrd_fsm_t fsm;
        logic [16:0] shreg;
        logic [4:0] left;
        logic [4:0] sent;
        logic [2:0] kind;
        logic link_request_line;
        logic [1:0] ctl_s1;
        logic [1:0] ctl_s2;
        logic [1:0] ctl_q;
        logic [1:0] dat_s1;
        logic [1:0] dat_s2;
        logic queued;
        logic [16:0] q_frame;
        logic [2:0] q_kind;
        logic bus_pending;
        logic lost_wait;
        logic [16:0] bus_frame;
        logic [2:0] bus_kind;
        logic won;
        logic lost;
        logic refused;
        logic rd_pending;
        logic rd_done;
        logic [15:0] stat_sh;
        logic [3:0] stat_cnt;
        logic [3:0] flags;
        logic [3:0] rd_addr;
        logic [7:0] rd_data;
        logic [3:0] guard;
        logic [1:0] rel_cnt;
        logic ctl_oe;
        logic mem_we;
        logic [3:0] mem_waddr;
        logic [7:0] mem_wdata;
        logic [3:0] mirror_sel;
        logic ws;
        logic [31:0] rdata;
    } lrd_regs_t;

endpackage : lrd_pkg

// >>> hdl/lrd_mirror_mem.sv
// Shadow copy of the phy registers, registered read port
`timescale 1ns/1ps
`default_nettype none

module lrd_mirror_mem #(
    parameter int AW = 4,
    parameter int DW = 8
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [DW-1:0] i_wdata,
    input wire logic [AW-1:0] i_raddr,
    output logic [DW-1:0] o_rdata
);

    typedef struct packed {
        logic [(1<<AW)-1:0][DW-1:0] mem;
        logic [DW-1:0] rdata;
    } lrd_mem_t;

    lrd_mem_t st;
    lrd_mem_t next_st;

    always_comb begin
        next_st = st;
        if (i_we) begin
            next_st.mem[i_waddr] = i_wdata;
        end
        next_st.rdata = st.mem[i_raddr];
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_rdata = st.rdata;

endmodule : lrd_mirror_mem

`default_nettype wire

// >>> hdl/lrd_link_ctrl.sv
// Link-side request line controller with Avalon-MM register port
`timescale 1ns/1ps
`default_nettype none
`include "lrd_consts.svh"

module lrd_link_ctrl (
    input wire logic I_REF_CLK,
    input wire logic I_RST,
    input wire logic [3:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    output logic [31:0] O_AVS_READDATA,
    output logic O_AVS_WAITREQUEST,
    output logic O_LINK_REQUEST_LINE,
    input wire logic I_INTERFACE_CONTROL_BIT_A,
    input wire logic I_INTERFACE_CONTROL_BIT_B,
    output logic O_INTERFACE_CONTROL_BIT_A,
    output logic O_INTERFACE_CONTROL_BIT_B,
    output logic O_INTERFACE_CONTROL_OE,
    input wire logic [1:0] I_DATA,
    output logic [1:0] O_DATA,
    output logic O_DATA_OE
);

    localparam int GUARD_CYC = (`LRD_ACK_GUARD_NS * `LRD_CLK_MHZ + 999) / 1000;

    lrd_pkg::lrd_regs_t st;
    lrd_pkg::lrd_regs_t next_st;
    logic [7:0] mirror_rdata;

    function automatic logic is_bus_kind(input logic [2:0] k);
        return (k == `LRD_REQ_IMM) || (k == `LRD_REQ_ISO) || (k == `LRD_REQ_PRI) || (k == `LRD_REQ_FAIR);
    endfunction : is_bus_kind

    function automatic logic needs_guard(input logic [2:0] k);
        return (k == `LRD_REQ_ISO) || (k == `LRD_REQ_PRI) || (k == `LRD_REQ_FAIR);
    endfunction : needs_guard

    function automatic logic [16:0] build_frame(input logic [2:0] k, input logic [3:0] prio,
                                                input logic [3:0] addr, input logic [7:0] data);
        logic [16:0] f;
        f = 17'h00000;
        if (k == `LRD_REQ_READ) begin
            f = {1'b1, k, addr, 1'b0, 8'h00};
        end else if (k == `LRD_REQ_WRITE) begin
            f = {1'b1, k, addr, data, 1'b0};
        end else begin
            f = {1'b1, k, 2'b00, prio, 1'b0, 6'h00};
        end
        return f;
    endfunction : build_frame

    function automatic logic [4:0] frame_len(input logic [2:0] k);
        logic [4:0] n;
        n = `LRD_LEN_BUS;
        if (k == `LRD_REQ_READ) begin
            n = `LRD_LEN_READ;
        end else if (k == `LRD_REQ_WRITE) begin
            n = `LRD_LEN_WRITE;
        end
        return n;
    endfunction : frame_len

    lrd_mirror_mem #(
        .AW(4),
        .DW(8)
    ) u_mirror (
        .i_clk(I_REF_CLK),
        .i_rst(I_RST),
        .i_we(st.mem_we),
        .i_waddr(st.mem_waddr),
        .i_wdata(st.mem_wdata),
        .i_raddr(st.mirror_sel),
        .o_rdata(mirror_rdata)
    );

    always_comb begin
        logic idle2;
        logic bus_wr;
        logic [2:0] wkind;
        logic clr_won;
        logic clr_lost;
        logic clr_ref;
        logic clr_rd;
        logic set_ref;
        logic launch_ok;
        idle2 = 1'b0;
        bus_wr = 1'b0;
        wkind = 3'h0;
        clr_won = 1'b0;
        clr_lost = 1'b0;
        clr_ref = 1'b0;
        clr_rd = 1'b0;
        set_ref = 1'b0;
        launch_ok = 1'b0;
        next_st = st;
        next_st.mem_we = 1'b0;

        // Two flops on every pin input before use
        next_st.ctl_s1 = {I_INTERFACE_CONTROL_BIT_A, I_INTERFACE_CONTROL_BIT_B};
        next_st.ctl_s2 = st.ctl_s1;
        next_st.ctl_q = st.ctl_s2;
        next_st.dat_s1 = I_DATA;
        next_st.dat_s2 = st.dat_s1;
        idle2 = (st.ctl_s2 == `LRD_CTL_IDLE) && (st.ctl_q == `LRD_CTL_IDLE);

        // Ack guard window after each received packet
        if (st.ctl_q == `LRD_CTL_RECEIVE && st.ctl_s2 == `LRD_CTL_IDLE) begin
            next_st.guard = 4'(GUARD_CYC);
        end else if (st.guard != 4'h0) begin
            next_st.guard = st.guard - 4'h1;
        end

        // Avalon slave: one wait cycle, then answer
        if (st.ws && (I_AVS_READ || I_AVS_WRITE)) begin
            next_st.ws = 1'b0;
            next_st.rdata = 32'h00000000;
            if (I_AVS_ADDRESS == `LRD_REG_CMD) begin
                next_st.rdata = {28'h0000000, st.queued, st.q_kind};
            end else if (I_AVS_ADDRESS == `LRD_REG_STATUS) begin
                next_st.rdata[`LRD_ST_PENDING] = st.bus_pending | st.lost_wait;
                next_st.rdata[`LRD_ST_WON] = st.won;
                next_st.rdata[`LRD_ST_LOST] = st.lost;
                next_st.rdata[`LRD_ST_REFUSED] = st.refused;
                next_st.rdata[`LRD_ST_RDDONE] = st.rd_done;
                next_st.rdata[`LRD_ST_RDPEND] = st.rd_pending;
                next_st.rdata[`LRD_ST_QUEUED] = st.queued;
                next_st.rdata[`LRD_ST_SENDING] = (st.fsm == lrd_pkg::LRD_SEND);
                next_st.rdata[`LRD_ST_FLAGS_LSB +: 4] = st.flags;
            end else if (I_AVS_ADDRESS == `LRD_REG_RESULT) begin
                next_st.rdata = {20'h00000, st.rd_addr, st.rd_data};
            end else if (I_AVS_ADDRESS == `LRD_REG_MIRROR) begin
                next_st.rdata = {20'h00000, st.mirror_sel, mirror_rdata};
            end
        end else begin
            next_st.ws = 1'b1;
        end

        // Register writes take effect on the cycle waitrequest is low
        if (!st.ws && I_AVS_WRITE) begin
            if (I_AVS_ADDRESS == `LRD_REG_CMD) begin
                wkind = I_AVS_WRITEDATA[`LRD_CMD_TYPE_LSB +: 3];
                bus_wr = is_bus_kind(wkind);
                if (st.queued || (wkind > `LRD_REQ_WRITE)) begin
                    set_ref = 1'b1;
                end else if (bus_wr && (st.bus_pending || st.lost_wait)) begin
                    set_ref = 1'b1;
                end else begin
                    next_st.queued = 1'b1;
                    next_st.q_kind = wkind;
                    next_st.q_frame = build_frame(wkind, I_AVS_WRITEDATA[`LRD_CMD_PRIO_LSB +: 4],
                                                  I_AVS_WRITEDATA[`LRD_CMD_ADDR_LSB +: 4],
                                                  I_AVS_WRITEDATA[`LRD_CMD_DATA_LSB +: 8]);
                end
            end else if (I_AVS_ADDRESS == `LRD_REG_STATUS) begin
                clr_won = I_AVS_WRITEDATA[`LRD_ST_WON];
                clr_lost = I_AVS_WRITEDATA[`LRD_ST_LOST];
                clr_ref = I_AVS_WRITEDATA[`LRD_ST_REFUSED];
                clr_rd = I_AVS_WRITEDATA[`LRD_ST_RDDONE];
            end else if (I_AVS_ADDRESS == `LRD_REG_MIRROR) begin
                next_st.mirror_sel = I_AVS_WRITEDATA[3:0];
            end
        end
        // Clears first so a same-cycle event still sets the flag
        if (clr_won) begin
            next_st.won = 1'b0;
        end
        if (clr_lost) begin
            next_st.lost = 1'b0;
        end
        if (clr_ref) begin
            next_st.refused = 1'b0;
        end
        if (clr_rd) begin
            next_st.rd_done = 1'b0;
        end
        if (set_ref) begin
            next_st.refused = 1'b1;
        end

        // Won: phy shows transmit while our bus request stands
        if (st.bus_pending && st.ctl_s2 == `LRD_CTL_TRANSMIT) begin
            next_st.bus_pending = 1'b0;
            next_st.won = 1'b1;
            next_st.rel_cnt = `LRD_RELEASE_CYC;
        end else if (st.bus_pending && st.bus_kind != `LRD_REQ_IMM && st.ctl_s2 == `LRD_CTL_RECEIVE) begin
            next_st.bus_pending = 1'b0;
            next_st.lost = 1'b1;
            next_st.lost_wait = 1'b1;
        end else if (st.bus_pending && st.bus_kind == `LRD_REQ_IMM && st.guard == 4'h1) begin
            // Ack grant never came in the window: drop it, no retry
            next_st.bus_pending = 1'b0;
            next_st.lost = 1'b1;
        end

        // No packet source here, so every grant is handed straight back
        if (st.rel_cnt != 2'h0) begin
            next_st.rel_cnt = st.rel_cnt - 2'h1;
            next_st.ctl_oe = 1'b1;
        end else begin
            next_st.ctl_oe = 1'b0;
        end

        // Status transfers from the phy
        if (st.ctl_s2 == `LRD_CTL_STATUS) begin
            next_st.stat_sh = {st.stat_sh[13:0], st.dat_s2[0], st.dat_s2[1]};
            if (st.stat_cnt != `LRD_STAT_FULL) begin
                next_st.stat_cnt = st.stat_cnt + 4'h1;
            end
        end else if (st.ctl_q == `LRD_CTL_STATUS) begin
            next_st.stat_cnt = 4'h0;
            // Broken off by a packet: phy resends, keep waiting
            if (st.ctl_s2 == `LRD_CTL_IDLE) begin
                if (st.stat_cnt == `LRD_STAT_FULL) begin
                    next_st.flags = st.stat_sh[15:12];
                    if (st.rd_pending) begin
                        next_st.rd_pending = 1'b0;
                        next_st.rd_done = 1'b1;
                        next_st.rd_addr = st.stat_sh[11:8];
                        next_st.rd_data = st.stat_sh[7:0];
                        next_st.mem_we = 1'b1;
                        next_st.mem_waddr = st.stat_sh[11:8];
                        next_st.mem_wdata = st.stat_sh[7:0];
                    end
                end else if (st.stat_cnt == `LRD_STAT_SHORT) begin
                    next_st.flags = st.stat_sh[3:0];
                end
            end
        end

        // Frame sender
        case (st.fsm)
            lrd_pkg::LRD_IDLE: begin
                next_st.link_request_line = 1'b0;
                if (st.lost_wait && idle2 && st.guard == 4'h0) begin
                    next_st.fsm = lrd_pkg::LRD_SEND;
                    next_st.lost_wait = 1'b0;
                    next_st.bus_pending = 1'b1;
                    next_st.kind = st.bus_kind;
                    next_st.link_request_line = st.bus_frame[16];
                    next_st.shreg = {st.bus_frame[15:0], 1'b0};
                    next_st.left = frame_len(st.bus_kind) - 5'h01;
                    next_st.sent = 5'h01;
                end else if (st.queued && !st.lost_wait) begin
                    if (st.q_kind == `LRD_REQ_PRI || st.q_kind == `LRD_REQ_FAIR) begin
                        launch_ok = idle2 && st.guard == 4'h0;
                    end else if (st.q_kind == `LRD_REQ_ISO) begin
                        launch_ok = st.guard == 4'h0;
                    end else begin
                        launch_ok = 1'b1;
                    end
                    if (launch_ok) begin
                        next_st.fsm = lrd_pkg::LRD_SEND;
                        next_st.queued = 1'b0;
                        next_st.kind = st.q_kind;
                        next_st.link_request_line = st.q_frame[16];
                        next_st.shreg = {st.q_frame[15:0], 1'b0};
                        next_st.left = frame_len(st.q_kind) - 5'h01;
                        next_st.sent = 5'h01;
                        if (is_bus_kind(st.q_kind)) begin
                            next_st.bus_pending = 1'b1;
                            next_st.bus_frame = st.q_frame;
                            next_st.bus_kind = st.q_kind;
                        end
                    end
                end
            end
            lrd_pkg::LRD_SEND: begin
                if (st.left != 5'h00) begin
                    next_st.link_request_line = st.shreg[16];
                    next_st.shreg = {st.shreg[15:0], 1'b0};
                    next_st.left = st.left - 5'h01;
                    next_st.sent = st.sent + 5'h01;
                end else begin
                    next_st.fsm = lrd_pkg::LRD_IDLE;
                    next_st.link_request_line = 1'b0;
                    if (st.kind == `LRD_REQ_READ) begin
                        next_st.rd_pending = 1'b1;
                    end else if (st.kind == `LRD_REQ_WRITE) begin
                        // Phy stores on frame end, mirror follows
                        next_st.mem_we = 1'b1;
                        next_st.mem_waddr = st.q_frame[12:9];
                        next_st.mem_wdata = st.q_frame[8:1];
                    end
                end
            end
            default: begin
                next_st.fsm = lrd_pkg::LRD_IDLE;
                next_st.link_request_line = 1'b0;
            end
        endcase
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            st <= '0;
            st.fsm <= lrd_pkg::LRD_IDLE;
            st.ws <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign O_AVS_READDATA = st.rdata;
    assign O_AVS_WAITREQUEST = st.ws;
    assign O_LINK_REQUEST_LINE = st.link_request_line;
    assign O_INTERFACE_CONTROL_BIT_A = 1'b0;
    assign O_INTERFACE_CONTROL_BIT_B = 1'b0;
    assign O_INTERFACE_CONTROL_OE = st.ctl_oe;
    assign O_DATA = 2'h0;
    assign O_DATA_OE = st.ctl_oe;

    a_line_rests_low: assert property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        st.fsm != lrd_pkg::LRD_SEND |-> !st.link_request_line)
        else $error("request line high outside a frame");

    a_frame_start_one: assert property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        $rose(st.fsm == lrd_pkg::LRD_SEND) |-> st.link_request_line)
        else $error("frame did not open with a one");

    a_frame_stop_zero: assert property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        $fell(st.fsm == lrd_pkg::LRD_SEND) |-> !$past(st.link_request_line))
        else $error("frame did not close with a zero");

    a_write_len_17: assert property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        $fell(st.fsm == lrd_pkg::LRD_SEND) && st.kind == `LRD_REQ_WRITE |-> st.sent == 5'h11)
        else $error("write frame length is not 17");

    a_read_len_9: assert property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        $fell(st.fsm == lrd_pkg::LRD_SEND) && st.kind == `LRD_REQ_READ |-> st.sent == 5'h09)
        else $error("read frame length is not 9");

    a_write_type_bits: assert property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        $rose(st.fsm == lrd_pkg::LRD_SEND) && st.kind == `LRD_REQ_WRITE
            |=> st.link_request_line ##1 !st.link_request_line ##1 st.link_request_line)
        else $error("write frame type is not 101");

    a_fair_after_idle: assert property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        $rose(st.fsm == lrd_pkg::LRD_SEND) && (st.kind == `LRD_REQ_PRI || st.kind == `LRD_REQ_FAIR)
            |-> $past(st.ctl_s2) == `LRD_CTL_IDLE && $past(st.ctl_q) == `LRD_CTL_IDLE)
        else $error("fair or priority request sent without idle clock");

    a_one_bus_request: assert property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        $rose(st.fsm == lrd_pkg::LRD_SEND) && is_bus_kind(st.kind) |-> !$past(st.bus_pending))
        else $error("second bus request while one is pending");

    a_ack_guard_wait: assert property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        $rose(st.fsm == lrd_pkg::LRD_SEND) && needs_guard(st.kind) |-> $past(st.guard) == 4'h0)
        else $error("request sent inside the acknowledge window");

    a_grant_released: assert property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        st.bus_pending && st.ctl_s2 == `LRD_CTL_TRANSMIT
            |=> ##1 O_INTERFACE_CONTROL_OE ##1 O_INTERFACE_CONTROL_OE ##1 !O_INTERFACE_CONTROL_OE)
        else $error("grant not handed back with two idle cycles");

    a_lost_reissue: assert property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        st.bus_pending && st.bus_kind != `LRD_REQ_IMM && st.ctl_s2 == `LRD_CTL_RECEIVE
            && st.ctl_s2 != `LRD_CTL_TRANSMIT |=> st.lost_wait && st.lost)
        else $error("receive during request not taken as lost");

endmodule : lrd_link_ctrl

`default_nettype wire

// >>> sim/lrd_phy_model.sv
// Behavioural phy model facing the link request controller
`timescale 1ns/1ps
`default_nettype none
module lrd_phy_model (
    input wire logic i_clk,
    input wire logic i_line,
    input wire logic i_lose,
    output logic [1:0] o_ctl,
    output logic [1:0] o_d
);
    logic [16:0] fr;
    logic [7:0] regs [16];
    logic [15:0] st;
    logic [1:0] dv;
    logic [1:0] tg = 2'h1;
    logic on;
    int len;
    // Data lines toggle when not carrying status, so a stale value never looks valid
    assign o_d = on ? dv : tg;
    always @(posedge i_clk) begin
        tg <= ~tg;
    end
    initial begin
        o_ctl = 2'h0;
        on = 1'b0;
        dv = 2'h0;
        // One frame at a time: requests arriving while busy are not seen
        forever begin
            @(posedge i_clk);
            if (i_line !== 1'b1) continue;
            fr = 17'h1;
            len = 11;
            for (int i = 1; i < len; i++) begin
                @(posedge i_clk);
                fr = {fr[15:0], i_line};
                if (i == 3) len = (fr[2:0] == 3'h5) ? 17 : (fr[2:0] == 3'h4) ? 9 : 11;
            end
            if (len == 17) begin
                regs[fr[12:9]] = fr[8:1];
            end else if (len == 9) begin
                st = {4'h0, fr[4:1], regs[fr[4:1]]};
                @(posedge i_clk);
                for (int k = 0; k < 8; k++) begin
                    o_ctl <= 2'h1;
                    on <= 1'b1;
                    dv <= {st[14-2*k], st[15-2*k]};
                    @(posedge i_clk);
                end
                o_ctl <= 2'h0;
                on <= 1'b0;
            end else if (fr[9:8] != 2'h3) begin
                @(posedge i_clk);
                o_ctl <= i_lose ? 2'h2 : 2'h3;
                repeat (i_lose ? 3 : 1) @(posedge i_clk);
                o_ctl <= 2'h0;
            end
        end
    end
endmodule : lrd_phy_model
`default_nettype wire

// >>> sim/lrd_link_ctrl_tb.sv
// Self-checking bench for the link request controller
`timescale 1ns/1ps
`default_nettype none
module lrd_link_ctrl_tb;
    logic clk, rst, rd, wr, waitreq, line, ca, cb, c_oe, d_oe, lose;
    logic [3:0] addr;
    logic [31:0] wdata, rdata, v;
    logic [1:0] d_o, phy_ctl, phy_d;
    logic [16:0] fr;
    int failures, total_checks;
    lrd_link_ctrl i_dut (.I_REF_CLK(clk), .I_RST(rst), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd), .I_AVS_WRITE(wr),
        .I_AVS_WRITEDATA(wdata), .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(waitreq), .O_LINK_REQUEST_LINE(line),
        .I_INTERFACE_CONTROL_BIT_A(c_oe ? ca : phy_ctl[1]), .I_INTERFACE_CONTROL_BIT_B(c_oe ? cb : phy_ctl[0]),
        .O_INTERFACE_CONTROL_BIT_A(ca), .O_INTERFACE_CONTROL_BIT_B(cb), .O_INTERFACE_CONTROL_OE(c_oe),
        .I_DATA(d_oe ? d_o : phy_d), .O_DATA(d_o), .O_DATA_OE(d_oe));
    lrd_phy_model i_phy (.i_clk(clk), .i_line(line), .i_lose(lose), .o_ctl(phy_ctl), .o_d(phy_d));
    function automatic logic [31:0] cmd(input logic [2:0] t, input logic [3:0] p, input logic [3:0] a,
        input logic [7:0] d);
        return {13'h0, d, a, p, t};
    endfunction : cmd
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Starts a clean edge first so strobes are never reassigned in one time step
    // Waits for the slave however long it takes; only the watchdog ends a hang
    task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= ~w;
        do begin
            @(posedge clk);
        end while (waitreq !== 1'b0);
        v = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : av
    task automatic poll(input int b);
        int t;
        t = 0;
        do begin
            av(1'b0, 4'h1, 32'h0);
            t++;
        end while (v[b] !== 1'b1 && t < 100);
        chk("status flag", 32'h1, {31'h0, v[b]});
    endtask : poll
    task automatic grab(input int n);
        int t;
        t = 0;
        while (line !== 1'b1 && t < 400) begin
            @(posedge clk);
            t++;
        end
        fr = 17'h1;
        for (int i = 1; i < n; i++) begin
            @(posedge clk);
            fr = {fr[15:0], line};
        end
    endtask : grab
    task automatic t_reset();
        av(1'b0, 4'h1, 32'h0);
        chk("status after reset", 32'h0, v);
        av(1'b1, 4'h7, 32'hFFFF_FFFF);
        av(1'b0, 4'h7, 32'h0);
        chk("unmapped read", 32'h0, v);
        for (int k = 6; k < 8; k++) begin
            av(1'b1, 4'h0, cmd(3'(k), 4'h0, 4'h0, 8'h0));
            poll(3);
            chk("line at rest", 32'h0, {31'h0, line});
            av(1'b1, 4'h1, 32'h1E);
        end
        $display("test reset done");
    endtask : t_reset
    task automatic t_write();
        av(1'b1, 4'h0, cmd(3'h5, 4'h0, 4'hA, 8'h5A));
        grab(17);
        chk("write frame", {15'h0, 1'b1, 3'h5, 4'hA, 8'h5A, 1'b0}, {15'h0, fr});
        repeat (3) @(posedge clk);
        chk("phy register", 32'h5A, {24'h0, i_phy.regs[10]});
        av(1'b1, 4'h3, 32'hA);
        av(1'b0, 4'h3, 32'h0);
        chk("mirror entry", 32'hA5A, v);
        $display("test write done");
    endtask : t_write
    task automatic t_read();
        av(1'b1, 4'h0, cmd(3'h4, 4'h0, 4'hA, 8'h0));
        grab(9);
        chk("read frame", {23'h0, 1'b1, 3'h4, 4'hA, 1'b0}, {15'h0, fr});
        poll(4);
        av(1'b0, 4'h2, 32'h0);
        chk("read result", 32'hA5A, v);
        av(1'b1, 4'h1, 32'h1E);
        $display("test read done");
    endtask : t_read
    task automatic t_bus();
        for (int k = 0; k < 4; k++) begin
            av(1'b1, 4'h0, cmd(3'(k), 4'h5, 4'h0, 8'h0));
            grab(11);
            chk("bus frame", {21'h0, 1'b1, 3'(k), 2'h0, 4'h5, 1'b0}, {15'h0, fr});
            poll(1);
            av(1'b1, 4'h1, 32'h1E);
            repeat (6) @(posedge clk);
        end
        $display("test bus done");
    endtask : t_bus
    task automatic t_lost();
        lose <= 1'b1;
        av(1'b1, 4'h0, cmd(3'h3, 4'h0, 4'h0, 8'h0));
        av(1'b1, 4'h0, cmd(3'h2, 4'h0, 4'h0, 8'h0));
        poll(3);
        poll(2);
        lose <= 1'b0;
        grab(11);
        chk("reissue frame", {21'h0, 1'b1, 3'h3, 6'h0, 1'b0}, {15'h0, fr});
        poll(1);
        av(1'b1, 4'h1, 32'h1E);
        $display("test lost done");
    endtask : t_lost
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        {rst, rd, wr, lose, addr, wdata} = {4'h8, 4'h0, 32'h0};
        failures = 0;
        total_checks = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_write();
        t_read();
        t_bus();
        t_lost();
        tally_and_finish();
    end
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        tally_and_finish();
    end
endmodule : lrd_link_ctrl_tb
`default_nettype wire
